// [rtl/lcdc_top.sv]
/*
  Dot-matrix LCD controller core: indexed 8-bit register port, display
  memory addressing, panel scan with scroll and blink, module standby.
  Assumes host port pins synchronous to CLK_IN; drive outputs are logic
  levels, 1 on a common meaning selected, 0 meaning non-selection.
*/
// Summary of operation
// - duty field: hi=1 gives 1/8, hi=0 lo=1 gives 1/16, else 1/32.
// - graphic mode drives 8/64, 16/56 or 32/40 commons and segments.
// - shared pins follow mode and duty; char 1/8 mirrors commons 1 to 8.
// - memory is 32 rows of 64 bits, x organised by five or eight bits.
// - byte msb is leftmost pixel; a one lights the dot.
// - character mode outputs 5 bits per byte, graphic mode all 8.
// - index written with select low; select high accesses indexed register.
// - only the display data register can be read.
// - memory reached via address then data register, address auto-advances.
// - direction 0 at 1/32 graphic: y steps, wraps at 1F, then x steps.
// - direction 1 at 1/32 graphic: x steps, wraps at 4, then y steps.
// - display memory is dual ported; refresh never disturbs host access.
// - read-modify-write mode advances address after writes only.
// - panel line one shows start line row, wrapping modulo duty.
// - blink toggles with about 1.6 s period at 80 Hz frames.
// - blink lines first to last, masked units blink when enabled.
// - blink area follows memory rows, so it scrolls with data.
// - standby stops supplies, grounds outputs, clears display and op-amp bits.
// - registers stay accessible during module standby.
// - chip standby switches supply off within two subclock cycles.
// - index captured on strobe fall with select and write both low.
`timescale 1ns/1ns
module lcdc_top #(
  parameter int LINE_CYCLES = lcdc_pkg::LINE_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] DB_IN,
  output logic [7:0] DB_OUT,
  output logic DB_OE_N_OUT,
  input wire logic RS_IN,
  input wire logic RW_IN,
  input wire logic STROBE_IN,
  input wire logic CHIP_STANDBY_IN,
  output logic [31:0] COM_OUT,
  output logic [63:0] SEG_OUT,
  output logic DRIVE_ON_OUT,
  output logic STEPUP_EN_OUT,
  output logic OPAMP_EN_OUT
);
  import lcdc_pkg::*;

  function automatic lcdc_pkg::lcdc_duty_t duty_of(input logic hi, input logic lo);
    duty_of = hi ? LCDC_DUTY8 : (lo ? LCDC_DUTY16 : LCDC_DUTY32);
  endfunction

  function automatic logic [4:0] last_line(input lcdc_pkg::lcdc_duty_t d);
    case (d)
      LCDC_DUTY8: last_line = 5'h07;
      LCDC_DUTY16: last_line = 5'h0F;
      default: last_line = 5'h1F;
    endcase
  endfunction

  function automatic logic [2:0] last_x(input logic gfx, input lcdc_pkg::lcdc_duty_t d);
    if (!gfx)
      last_x = 3'h7;
    else if (d == LCDC_DUTY16)
      last_x = 3'h6;
    else if (d == LCDC_DUTY32)
      last_x = 3'h4;
    else
      last_x = 3'h7;
  endfunction

  logic strobe_d_ff;
  logic [7:0] index_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [2:0] x_ff;
  logic [4:0] y_ff;
  logic [7:0] bmask_ff;
  logic [4:0] start_ff;
  logic [4:0] bfirst_ff;
  logic [4:0] blast_ff;
  logic [7:0] rd_ff;
  logic drive_ff;
  logic [$clog2(LINE_CYCLES)-1:0] div_ff;
  logic [4:0] line_ff;
  logic [31:0] com_ff;
  logic [63:0] seg_ff;
  logic drv_ff;
  logic stepup_ff;
  logic opamp_ff;

  logic fall;
  logic rise;
  logic wr_ctl;
  logic wr_data;
  logic rd_take;
  logic advance;
  logic standby;
  logic gfx;
  lcdc_duty_t duty;
  logic [4:0] ymax;
  logic [2:0] xmax;
  logic [7:0] mem_rd;
  logic [4:0] scan_y;
  logic [63:0] row;
  logic line_tick;
  logic frame_tick;
  logic hide;
  logic in_blink;
  logic [63:0] nxt_seg;
  logic [31:0] nxt_com;
  logic [4:0] nxt_y;
  logic [2:0] nxt_x;

  assign fall = strobe_d_ff & ~STROBE_IN;
  assign rise = ~strobe_d_ff & STROBE_IN;
  assign wr_ctl = fall & RS_IN & ~RW_IN;
  assign wr_data = wr_ctl & (index_ff == IDX_DATA);
  assign rd_take = rise & RS_IN & RW_IN & (index_ff == IDX_DATA);
  assign advance = wr_data | (rd_take & ~ctrl2_ff[C2_RMW]);
  assign standby = ctrl1_ff[C1_STBY] | CHIP_STANDBY_IN;
  assign gfx = ctrl1_ff[C1_MODE];
  assign duty = duty_of(ctrl1_ff[C1_DUTY_HI], ctrl1_ff[C1_DUTY_LO]);
  assign ymax = last_line(duty);
  assign xmax = last_x(gfx, duty);

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      strobe_d_ff <= 1'b0;
    else
      strobe_d_ff <= STROBE_IN;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      index_ff <= 8'h00;
    else if (fall && !RS_IN && !RW_IN)
      index_ff <= DB_IN;
  end

  // control writes stay open in standby
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      ctrl1_ff <= CTRL1_RST;
      ctrl2_ff <= CTRL2_RST;
      bmask_ff <= 8'h00;
      start_ff <= 5'h00;
      bfirst_ff <= 5'h00;
      blast_ff <= 5'h00;
    end
    else
    begin
      if (wr_ctl && index_ff == IDX_CTRL1)
        ctrl1_ff <= DB_IN;
      if (wr_ctl && index_ff == IDX_CTRL2)
        ctrl2_ff <= DB_IN;
      else if (standby)
      begin
        ctrl2_ff[C2_DISPLAY_ON] <= 1'b0;
        ctrl2_ff[C2_OPAMP_ENABLE] <= 1'b0;
      end
      if (wr_ctl && index_ff == IDX_BMASK)
        bmask_ff <= DB_IN;
      if (wr_ctl && index_ff == IDX_START)
        start_ff <= DB_IN[4:0];
      if (wr_ctl && index_ff == IDX_BFIRST)
        bfirst_ff <= DB_IN[4:0];
      if (wr_ctl && index_ff == IDX_BLAST)
        blast_ff <= DB_IN[4:0];
    end
  end

  // address step: direction 0 walks y then x, direction 1 walks x then y
  always_comb
  begin
    nxt_x = x_ff;
    nxt_y = y_ff;
    if (!ctrl2_ff[C2_INC])
    begin
      nxt_y = (y_ff >= ymax) ? 5'h00 : y_ff + 5'h01;
      if (y_ff >= ymax)
        nxt_x = (x_ff >= xmax) ? 3'h0 : x_ff + 3'h1;
    end
    else
    begin
      nxt_x = (x_ff >= xmax) ? 3'h0 : x_ff + 3'h1;
      if (x_ff >= xmax)
        nxt_y = (y_ff >= ymax) ? 5'h00 : y_ff + 5'h01;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      x_ff <= 3'h0;
      y_ff <= 5'h00;
    end
    else if (wr_ctl && index_ff == IDX_ADDR)
    begin
      x_ff <= DB_IN[7:ADDR_X_LSB];
      y_ff <= DB_IN[4:0];
    end
    else if (advance)
    begin
      x_ff <= nxt_x;
      y_ff <= nxt_y;
    end
  end

  // read data appears on strobe rise, bus released once write is selected
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      rd_ff <= 8'h00;
      drive_ff <= 1'b0;
    end
    else if (rd_take)
    begin
      rd_ff <= mem_rd;
      drive_ff <= 1'b1;
    end
    else if (!RW_IN || !RS_IN)
    begin
      rd_ff <= 8'h00;
      drive_ff <= 1'b0;
    end
  end

  assign DB_OUT = rd_ff;
  assign DB_OE_N_OUT = ~drive_ff;

  lcdc_dpram u_mem (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .wr_en_in(wr_data),
    .x_in(x_ff),
    .y_in(y_ff),
    .wr_data_in(DB_IN),
    .rd_data_out(mem_rd),
    .display_on_y_in(scan_y),
    .display_on_row_out(row)
  );

  // line divider and line counter
  assign line_tick = (div_ff == ($clog2(LINE_CYCLES))'(LINE_CYCLES - 1));
  assign frame_tick = line_tick && line_ff == ymax;

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN || line_tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      line_ff <= 5'h00;
    else if (line_tick)
      line_ff <= (line_ff >= ymax) ? 5'h00 : line_ff + 5'h01;
  end

  assign scan_y = (start_ff + line_ff) & ymax;

  lcdc_blink u_blink (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .frame_tick_in(frame_tick),
    .hide_out(hide)
  );

  // blink window in memory rows, so it scrolls with the data
  assign in_blink = ctrl2_ff[C2_BLK] && hide && scan_y >= bfirst_ff
    && scan_y <= blast_ff;

  always_comb
  begin
    nxt_seg = '0;
    for (int b = 0; b < MEM_X_BYTES; b++)
    begin
      if (!(in_blink && bmask_ff[7-b]))
      begin
        if (gfx)
          nxt_seg[8*b +: 8] = {<<{row[63-8*b -: 8]}};
        else if (b < 8)
          nxt_seg[5*b +: 5] = {<<{row[63-8*b -: 5]}};
      end
    end
    if (gfx && duty == LCDC_DUTY16)
      nxt_seg[63:56] = 8'h00;
    else if (gfx && duty == LCDC_DUTY32)
      nxt_seg[63:40] = 24'h000000;
    if (!gfx)
      nxt_seg[63:40] = 24'h000000;
  end

  // common select with shared pins per mode and duty
  always_comb
  begin
    nxt_com = 32'h00000001 << line_ff;
    case ({gfx, duty})
      {1'b0, LCDC_DUTY8}:
        nxt_com[31:8] = {8'h00, nxt_com[7:0], 8'h00};
      {1'b0, LCDC_DUTY16}:
        nxt_com[31:16] = nxt_com[15:0];
      {1'b1, LCDC_DUTY8}:
        nxt_com[31:8] = 24'h000000;
      {1'b1, LCDC_DUTY16}:
        nxt_com[31:16] = 16'h0000;
      default:
        nxt_com = nxt_com;
    endcase
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN || standby || !ctrl2_ff[C2_DISPLAY_ON])
    begin
      com_ff <= 32'h00000000;
      seg_ff <= 64'h0000000000000000;
      drv_ff <= 1'b0;
    end
    else
    begin
      com_ff <= nxt_com;
      seg_ff <= nxt_seg;
      drv_ff <= 1'b1;
    end
  end

  // supplies drop on the first edge of standby, well inside two subclocks
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN || standby)
    begin
      stepup_ff <= 1'b0;
      opamp_ff <= 1'b0;
    end
    else
    begin
      stepup_ff <= ctrl1_ff[C1_PWR];
      opamp_ff <= ctrl2_ff[C2_OPAMP_ENABLE];
    end
  end

  assign COM_OUT = com_ff;
  assign SEG_OUT = seg_ff;
  assign DRIVE_ON_OUT = drv_ff;
  assign STEPUP_EN_OUT = stepup_ff;
  assign OPAMP_EN_OUT = opamp_ff;

  AST_INDEX_CAPTURE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    fall && !RS_IN && !RW_IN |=> index_ff == $past(DB_IN))
    else $error("index not captured on strobe fall");

  AST_ONLY_DATA_READ: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(drive_ff) |-> $past(index_ff) == IDX_DATA && $past(RW_IN))
    else $error("bus driven for a non-data register");

  AST_RMW_HOLD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    rd_take && ctrl2_ff[C2_RMW] |=> $stable(x_ff) && $stable(y_ff))
    else $error("address moved after read in rmw mode");

  AST_Y_WRAP: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    advance && !ctrl2_ff[C2_INC] && gfx && duty == LCDC_DUTY32 && y_ff == 5'h1F
    && x_ff != 3'h4 |=> y_ff == 5'h00 && x_ff == $past(x_ff) + 3'h1)
    else $error("y wrap did not carry into x");

  AST_X_WRAP: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    advance && ctrl2_ff[C2_INC] && gfx && duty == LCDC_DUTY32 && x_ff == 3'h4
    |=> x_ff == 3'h0 && y_ff == (($past(y_ff) == 5'h1F) ? 5'h00 : $past(y_ff) + 5'h01))
    else $error("x wrap did not carry into y");

  AST_STANDBY_DARK: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    standby |=> COM_OUT == 32'h00000000 && SEG_OUT == '0 && !DRIVE_ON_OUT
    && (!ctrl2_ff[C2_DISPLAY_ON] || $past(wr_ctl && index_ff == IDX_CTRL2)))
    else $error("outputs not grounded in standby");

  AST_SUPPLY_OFF: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CHIP_STANDBY_IN |=> !STEPUP_EN_OUT && !OPAMP_EN_OUT)
    else $error("supply still on in chip standby");

  AST_SCROLL_ROW: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    line_ff == 5'h00 |-> scan_y == (start_ff & ymax))
    else $error("panel line one not at start line");

  AST_GFX8_SEGS: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    gfx && duty == LCDC_DUTY32 |=> SEG_OUT[63:40] == 24'h000000)
    else $error("unused segments driven at 1/32 graphic");
endmodule

// [rtl/lcdc_pkg.sv]
/*
  Shared constants of the dot-matrix LCD controller: register indices,
  control field positions, memory geometry and timing.
  Assumes a 125 MHz system clock.
*/
package lcdc_pkg;
  localparam logic [7:0] IDX_CTRL1 = 8'h00;
  localparam logic [7:0] IDX_CTRL2 = 8'h01;
  localparam logic [7:0] IDX_ADDR = 8'h02;
  localparam logic [7:0] IDX_DATA = 8'h04;
  localparam logic [7:0] IDX_BMASK = 8'h06;
  localparam logic [7:0] IDX_START = 8'h07;
  localparam logic [7:0] IDX_BFIRST = 8'h08;
  localparam logic [7:0] IDX_BLAST = 8'h09;
  // control_one fields
  localparam int C1_STBY = 0;
  localparam int C1_DUTY_LO = 1;
  localparam int C1_DUTY_HI = 2;
  localparam int C1_MODE = 3;
  localparam int C1_PWR = 4;
  // control_two fields
  localparam int C2_INC = 0;
  localparam int C2_RMW = 1;
  localparam int C2_BLK = 2;
  localparam int C2_DISPLAY_ON = 3;
  localparam int C2_OPAMP_ENABLE = 4;
  // address register layout: x in [7:5], y in [4:0]
  localparam int ADDR_X_LSB = 5;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam int MEM_X_BYTES = 8;
  localparam int MEM_Y_ROWS = 32;
  localparam int CLK_HZ = 125000000;
  localparam int FRAME_HZ = 80;
  localparam int BLINK_PERIOD_MS = 1600;
  localparam int BLINK_HALF_FRAMES = FRAME_HZ * BLINK_PERIOD_MS / 1000 / 2;
  localparam int LINE_CYCLES = CLK_HZ / (FRAME_HZ * MEM_Y_ROWS);
  typedef enum logic [1:0] {
    LCDC_DUTY32 = 2'h0,
    LCDC_DUTY16 = 2'h1,
    LCDC_DUTY8 = 2'h2
  } lcdc_duty_t;
endpackage

// [rtl/lcdc_dpram.sv]
/*
  Dual-port display memory, 32 rows of 8 bytes held in flip-flops.
  Host port writes and reads one byte; display port reads a whole row.
*/
`timescale 1ns/1ns
module lcdc_dpram #(
  parameter int X_BYTES = lcdc_pkg::MEM_X_BYTES,
  parameter int Y_ROWS = lcdc_pkg::MEM_Y_ROWS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [2:0] x_in,
  input wire logic [4:0] y_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  input wire logic [4:0] display_on_y_in,
  output logic [8*X_BYTES-1:0] display_on_row_out
);
  import lcdc_pkg::*;
  logic [7:0] mem_ff [X_BYTES*Y_ROWS];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
      mem_ff[{y_in, x_in}] <= wr_data_in;
  end

  assign rd_data_out = mem_ff[{y_in, x_in}];

  // byte 0 leftmost, msb leftmost within the byte
  always_comb
  begin
    for (int b = 0; b < X_BYTES; b++)
      display_on_row_out[8*(X_BYTES-b)-1 -: 8] = mem_ff[{display_on_y_in, 3'(b)}];
  end

  AST_MEM_WRITE_LANDS: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_en_in |=> mem_ff[$past({y_in, x_in})] == $past(wr_data_in))
    else $error("written byte not read back");
endmodule

// [rtl/lcdc_blink.sv]
/*
  Blink phase generator, toggling every half blink period counted in frames.
  Assumes one frame_tick_in pulse per display frame.
*/
`timescale 1ns/1ns
module lcdc_blink #(
  parameter int HALF_FRAMES = lcdc_pkg::BLINK_HALF_FRAMES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic frame_tick_in,
  output logic hide_out
);
  import lcdc_pkg::*;
  logic [$clog2(HALF_FRAMES)-1:0] frame_cnt_ff;
  logic hide_ff;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      frame_cnt_ff <= '0;
    else if (frame_tick_in)
      frame_cnt_ff <= (frame_cnt_ff == ($clog2(HALF_FRAMES))'(HALF_FRAMES - 1)) ? '0
        : frame_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      hide_ff <= 1'b0;
    else if (frame_tick_in && frame_cnt_ff == ($clog2(HALF_FRAMES))'(HALF_FRAMES - 1))
      hide_ff <= ~hide_ff;
  end

  assign hide_out = hide_ff;

  AST_BLINK_ON_FRAME: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(hide_ff) |-> $past(frame_tick_in)
    && $past(frame_cnt_ff) == ($clog2(HALF_FRAMES))'(HALF_FRAMES - 1))
    else $error("blink phase moved off a half-period boundary");
endmodule

// [bench/lcdc_host.sv]
/*
  Host cpu model driving the indexed register port of the lcd controller.
  Assumes it shares one clock with the design.
*/
`timescale 1ns/1ns
module lcdc_host (
  input wire logic clk_in,
  input wire logic [7:0] dev_db_in,
  input wire logic dev_oe_n_in,
  output logic [7:0] db_out,
  output logic rs_out,
  output logic rw_out,
  output logic strobe_out
);
  logic [7:0] db_ff = 8'h00;
  logic rs_ff = 1'b0, rw_ff = 1'b0, stb_ff = 1'b0;
  // wire level: device data while it drives, else host value
  assign db_out = dev_oe_n_in ? db_ff : dev_db_in;
  assign rs_out = rs_ff;
  assign rw_out = rw_ff;
  assign strobe_out = stb_ff;
  // select low writes the index, high the indexed register
  task automatic put(input logic rs, input logic [7:0] d);
    @(posedge clk_in);
    rs_ff <= rs;
    rw_ff <= 1'b0;
    db_ff <= d;
    stb_ff <= 1'b1;
    // extra cycle lets a read answer leave the bus first
    repeat (2) @(posedge clk_in);
    stb_ff <= 1'b0;
    // selects held through the falling strobe
    @(posedge clk_in);
  endtask
  task automatic get(output logic [7:0] d, output logic oe_n);
    @(posedge clk_in);
    rs_ff <= 1'b1;
    rw_ff <= 1'b1;
    stb_ff <= 1'b0;
    // released bus shows the inverse of the last value
    db_ff <= ~db_ff;
    @(posedge clk_in);
    stb_ff <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    d = dev_db_in;
    oe_n = dev_oe_n_in;
  endtask
endmodule

// [bench/tb_top.sv]
/*
  Self-checking bench of the lcd controller top.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ns
module tb_top;
  import lcdc_pkg::*;
  localparam int LC = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic csb = 1'b0;
  logic [7:0] db_in, db_out, d;
  logic oe_n, rs, rw, stb, drv, stu, opa, o;
  logic [31:0] com;
  logic [63:0] seg;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  lcdc_top #(.LINE_CYCLES(LC)) u_dut (.CLK_IN(clk), .RST_IN(rst), .DB_IN(db_in),
    .DB_OUT(db_out), .DB_OE_N_OUT(oe_n), .RS_IN(rs), .RW_IN(rw), .STROBE_IN(stb),
    .CHIP_STANDBY_IN(csb), .COM_OUT(com), .SEG_OUT(seg), .DRIVE_ON_OUT(drv),
    .STEPUP_EN_OUT(stu), .OPAMP_EN_OUT(opa));
  lcdc_host u_host (.clk_in(clk), .dev_db_in(db_out), .dev_oe_n_in(oe_n),
    .db_out(db_in), .rs_out(rs), .rw_out(rw), .strobe_out(stb));
  task automatic chk(input string w, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    wait (cyc == 20000);
    err_total++;
    conclude();
  end
  function automatic logic [7:0] f1(input logic s, input logic hi, input logic lo,
    input logic m);
    f1 = 8'(s) << C1_STBY | 8'(hi) << C1_DUTY_HI | 8'(lo) << C1_DUTY_LO
      | 8'(m) << C1_MODE | 8'h01 << C1_PWR;
  endfunction
  // display and op-amp on, unused bits zero
  function automatic logic [7:0] f2(input logic inc, input logic read_modify_write_mode);
    f2 = 8'(inc) << C2_INC | 8'(read_modify_write_mode) << C2_RMW | 8'h01 << C2_DISPLAY_ON | 8'h01 << C2_OPAMP_ENABLE;
  endfunction
  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    u_host.put(1'b0, idx);
    u_host.put(1'b1, v);
  endtask
  // point at x, y and select the data register
  task automatic sa(input logic [2:0] x, input logic [4:0] y);
    wreg(IDX_ADDR, {x, y});
    u_host.put(1'b0, IDX_DATA);
  endtask
  task automatic rdchk(input string w, input logic [7:0] e);
    u_host.get(d, o);
    chk(w, o, 1'b0);
    chk(w, d, e);
  endtask
  // wait for a fresh start of panel line k
  task automatic wcom(input int k);
    int n;
    n = 0;
    while (com[k] !== 1'b0 && n < 2000) @(negedge clk) n++;
    while (com[k] !== 1'b1 && n < 2000) @(negedge clk) n++;
    chk("line reached", n < 2000, 1'b1);
  endtask
  task automatic t_refuse();
    @(negedge clk);
    chk("reset oe", oe_n, 1'b1);
    chk("reset supplies", {drv, stu, opa}, 3'b000);
    wreg(IDX_CTRL2, f2(1'b0, 1'b0));
    u_host.get(d, o);
    chk("ctrl read oe", o, 1'b1);
    $display("test refuse done");
  endtask
  task automatic t_incy();
    wreg(IDX_CTRL1, f1(1'b0, 1'b0, 1'b0, 1'b1));
    sa(3'h0, 5'h1F);
    u_host.put(1'b1, 8'h11);
    u_host.put(1'b1, 8'h22);
    sa(3'h1, 5'h00);
    rdchk("y wrap", 8'h22);
    sa(3'h0, 5'h1F);
    rdchk("y first", 8'h11);
    rdchk("y next", 8'h22);
    $display("test incy done");
  endtask
  task automatic t_incx();
    wreg(IDX_CTRL2, f2(1'b1, 1'b0));
    sa(3'h4, 5'h03);
    u_host.put(1'b1, 8'h33);
    u_host.put(1'b1, 8'h44);
    sa(3'h0, 5'h04);
    rdchk("x wrap", 8'h44);
    sa(3'h4, 5'h03);
    rdchk("x first", 8'h33);
    rdchk("x next", 8'h44);
    $display("test incx done");
  endtask
  task automatic t_rmw();
    wreg(IDX_CTRL2, f2(1'b0, 1'b0));
    sa(3'h2, 5'h05);
    u_host.put(1'b1, 8'h55);
    u_host.put(1'b1, 8'h66);
    wreg(IDX_CTRL2, f2(1'b0, 1'b1));
    sa(3'h2, 5'h05);
    rdchk("rmw read", 8'h55);
    rdchk("rmw hold", 8'h55);
    u_host.put(1'b1, 8'h77);
    rdchk("rmw step", 8'h66);
    sa(3'h2, 5'h05);
    rdchk("rmw back", 8'h77);
    $display("test rmw done");
  endtask
  task automatic t_panel();
    wreg(IDX_CTRL2, f2(1'b0, 1'b0));
    wreg(IDX_CTRL1, f1(1'b0, 1'b1, 1'b0, 1'b1));
    sa(3'h0, 5'h00);
    u_host.put(1'b1, 8'hC1);
    sa(3'h7, 5'h00);
    u_host.put(1'b1, 8'h01);
    wcom(0);
    chk("graphic left", seg[7:0], 8'h83);
    chk("graphic right", seg[63:56], 8'h80);
    wreg(IDX_CTRL1, f1(1'b0, 1'b1, 1'b0, 1'b0));
    wcom(0);
    chk("char left", seg[4:0], 5'h03);
    chk("char mirror", {com[16], com[8]}, 2'b10);
    wreg(IDX_CTRL1, f1(1'b0, 1'b0, 1'b1, 1'b0));
    wreg(IDX_START, 8'h01);
    wcom(15);
    chk("scroll line", seg[4:0], 5'h03);
    $display("test panel done");
  endtask
  task automatic t_standby();
    chk("running", {drv, stu, opa}, 3'b111);
    // module standby requested before chip standby
    wreg(IDX_CTRL1, f1(1'b1, 1'b0, 1'b1, 1'b0));
    repeat (2) @(negedge clk);
    chk("standby supplies", {drv, stu, opa}, 3'b000);
    chk("standby com", com, 32'h0);
    chk("standby seg", seg, 64'h0);
    sa(3'h0, 5'h00);
    rdchk("standby read", 8'hC1);
    wreg(IDX_CTRL1, f1(1'b0, 1'b0, 1'b1, 1'b0));
    repeat (2) @(negedge clk);
    chk("bits lost", {drv, opa}, 2'b00);
    wreg(IDX_CTRL2, f2(1'b0, 1'b0));
    repeat (2) @(negedge clk);
    chk("restart", {drv, stu, opa}, 3'b111);
    @(posedge clk);
    csb <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("chip standby", stu, 1'b0);
    @(posedge clk);
    csb <= 1'b0;
    $display("test standby done");
  endtask
  // row 0 byte 0 blinks, rows 1 and byte 7 stay lit
  task automatic t_blink();
    int n;
    wreg(IDX_CTRL1, f1(1'b0, 1'b1, 1'b0, 1'b1));
    wreg(IDX_START, 8'h00);
    sa(3'h0, 5'h01);
    u_host.put(1'b1, 8'hC1);
    wreg(IDX_BMASK, 8'h80);
    wreg(IDX_BFIRST, 8'h00);
    wreg(IDX_BLAST, 8'h00);
    wreg(IDX_CTRL2, f2(1'b0, 1'b0) | 8'h01 << C2_BLK);
    // sync to the first hidden frame
    n = 0;
    wcom(0);
    while (seg[7:0] !== 8'h83 && n < 140)
    begin
      n++;
      wcom(0);
    end
    n = 0;
    while (seg[7:0] !== 8'h00 && n < 140)
    begin
      n++;
      wcom(0);
    end
    chk("blink hides", seg[7:0], 8'h00);
    chk("blink unmasked", seg[63:56], 8'h80);
    wcom(1);
    chk("blink outside", seg[7:0], 8'h83);
    n = 1;
    wcom(0);
    while (seg[7:0] === 8'h00 && n < 140)
    begin
      n++;
      wcom(0);
    end
    chk("blink half period", n, BLINK_HALF_FRAMES);
    wreg(IDX_START, 8'h01);
    // row wrapping into view rewritten only after the scroll
    sa(3'h0, 5'h00);
    u_host.put(1'b1, 8'hC1);
    n = 0;
    wcom(7);
    while (seg[7:0] !== 8'h00 && n < 140)
    begin
      n++;
      wcom(7);
    end
    chk("blink scrolls", seg[7:0], 8'h00);
    wcom(0);
    chk("scrolled row lit", seg[7:0], 8'h83);
    $display("test blink done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_refuse();
    t_incy();
    t_incx();
    t_rmw();
    t_panel();
    t_standby();
    t_blink();
    conclude();
  end
endmodule
